// ### verif/ast_rx_model.sv
// Remote asynchronous receiver model watching the transmit line
`timescale 1ns/1ps
module ast_rx_model (
	input  wire logic        sys_clk_in,
	input  wire logic        line_in,
	input  wire logic        nine_in,
	input  wire logic [15:0] bit_cyc_in,
	output logic [8:0]       word_out,
	output logic [7:0]       count_out,
	output logic [7:0]       ferr_out
);
	// ****************
	// Frame receiver
	// ****************
	logic       prev;
	logic [8:0] acc;
	int         nb;
	// Falling edges sampled off the design's edge to avoid races
	initial begin
		word_out = 9'h000;
		count_out = 8'h00;
		ferr_out = 8'h00;
		prev = 1'b1;
		forever begin
			@(negedge sys_clk_in);
			if (prev === 1'b1 && line_in === 1'b0) begin
				repeat (bit_cyc_in / 2) @(negedge sys_clk_in);
				if (line_in !== 1'b0) ferr_out++;
				acc = 9'h000;
				nb = nine_in ? 9 : 8;
				for (int i = 0; i < nb; i++) begin
					repeat (bit_cyc_in) @(negedge sys_clk_in);
					acc[i] = line_in; // Lowest bit first
				end
				repeat (bit_cyc_in) @(negedge sys_clk_in);
				if (line_in !== 1'b1) ferr_out++; // One stop
				word_out = acc;
				count_out++;
			end
			prev = line_in;
		end
	end
endmodule

// ### verif/testbench.sv
// Testbench: register-level tests of the serial transmitter
`timescale 1ns/1ps
module testbench;
	import ast_pkg::*;
	localparam logic [15:0] DIVS [3] = '{16'h0001, 16'h0100, 16'h0002};
	localparam logic [7:0]  CTLS [3] = '{8'h25, 8'h1D, 8'h4D};
	logic        clk;
	logic        srst;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [7:0]  pa;
	logic [31:0] pwd;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic        txl;
	logic        irq;
	logic        nine;
	logic [15:0] bcyc;
	logic [15:0] dv;
	logic [8:0]  word;
	logic [7:0]  cnt;
	logic [7:0]  ferr;
	logic [7:0]  d0;
	logic [31:0] q;
	logic        e;
	logic        n9;
	int          rxn;
	int          n_mismatch;
	int          compares;

	// ****************
	// Clock and parts
	// ****************
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	ast_tx i_dut (
		.sys_clk_in  (clk),
		.srst_in     (srst),
		.psel_in     (psel),
		.penable_in  (pen),
		.pwrite_in   (pwr),
		.paddr_in    (pa),
		.pwdata_in   (pwd),
		.prdata_out  (prd),
		.pready_out  (prdy),
		.pslverr_out (perr),
		.tx_line_out (txl),
		.irq_out     (irq)
	);
	ast_rx_model i_rx (
		.sys_clk_in (clk),
		.line_in    (txl),
		.nine_in    (nine),
		.bit_cyc_in (bcyc),
		.word_out   (word),
		.count_out  (cnt),
		.ferr_out   (ferr)
	);

	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One transfer; pready, data and error all taken at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (prdy !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			n_mismatch++;
			end_of_test();
		end else begin
			q = prd;
			e = perr;
			psel <= 1'b0;
			pen <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q & m, x);
	endtask
	// Looked at mid-cycle; returns on a rising edge for the next driver
	task automatic chk_irq(input logic x);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, x});
		@(posedge clk);
	endtask
	// Bounded wait for a given number of received frames
	task automatic wait_rx(input int t);
		int n;
		n = 0;
		while (cnt !== 8'(t) && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			n_mismatch++;
			end_of_test();
		end
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		pa = 8'h00;
		pwd = 32'h0;
		nine = 1'b0;
		bcyc = 16'd32;
		rxn = 0;
		n_mismatch = 0;
		compares = 0;
		srst = 1'b1;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rd_chk(OFF_CTRL, 32'hFF, {24'h0, CTRL_RESET});
		rd_chk(OFF_BAUD, 32'hFFFF, {16'h0, BAUD_RESET});
		rd_chk(8'h40, 32'hFFFFFFFF, RD_ZERO);
		chk({31'h0, e}, 32'h1);
		chk({31'h0, txl}, 32'h1);
		// Three baud and format settings, two back-to-back bytes each
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, OFF_CTRL, 32'h0);
			apb(1'b1, OFF_DATA, 32'hFF);
			rd_chk(OFF_STATUS, 32'h1, 32'h0);
			chk_irq(1'b0);
			chk({31'h0, txl}, 32'h1);
			apb(1'b1, OFF_BAUD, {16'h0, DIVS[k]});
			apb(1'b1, OFF_CTRL, {24'h0, CTLS[k]});
			rd_chk(OFF_STATUS, 32'h1, 32'h1);
			apb(1'b1, OFF_STATUS, 32'h3);
			rd_chk(OFF_STATUS, 32'h1, 32'h1);
			dv = CTLS[k][6] ? DIVS[k] : {8'h00, DIVS[k][7:0]};
			bcyc = (dv + 16'd1) * ((CTLS[k][5] | CTLS[k][6]) ?
				{9'h0, OVS_16} : {9'h0, OVS_64});
			nine = CTLS[k][3];
			n9 = CTLS[k][3] & CTLS[k][4];
			d0 = 8'hA5 ^ 8'(k);
			apb(1'b1, OFF_DATA, {24'h0, d0});
			apb(1'b1, OFF_DATA, 32'h3C);
			rd_chk(OFF_STATUS, 32'h3, 32'h0);
			wait_rx(rxn + 1);
			chk({23'h0, word}, {23'h0, n9, d0});
			wait_rx(rxn + 2);
			chk({23'h0, word}, {23'h0, n9, 8'h3C});
			rxn = rxn + 2;
			// Model counts at mid stop bit; let the stop bit finish
			repeat (bcyc) @(posedge clk);
			rd_chk(OFF_STATUS, 32'h3, 32'h3);
		end
		// Frame-done event: raise, mask, clear
		rd_chk(OFF_ISTAT, 32'h2, 32'h2);
		apb(1'b1, OFF_IMASK, 32'h2);
		chk_irq(1'b1);
		apb(1'b1, OFF_IMASK, 32'h0);
		chk_irq(1'b0);
		apb(1'b1, OFF_IMASK, 32'h2);
		apb(1'b1, OFF_ISTAT, 32'h2);
		chk_irq(1'b0);
		rd_chk(OFF_ISTAT, 32'h2, 32'h0);
		// Empty flag drives the request only once enabled
		apb(1'b1, OFF_IMASK, 32'h1);
		chk_irq(1'b0);
		apb(1'b1, OFF_CTRL, 32'h85);
		chk_irq(1'b1);
		chk({24'h0, ferr}, 32'h0);
		chk({24'h0, cnt}, 32'(rxn));
		// Clocked mode selected: a written byte must never leave
		apb(1'b1, OFF_CTRL, 32'h07);
		apb(1'b1, OFF_DATA, 32'h00);
		repeat (16) @(negedge clk);
		chk({31'h0, txl}, 32'h1);
		@(posedge clk);
		rd_chk(OFF_STATUS, 32'h3, 32'h2);
		chk({24'h0, cnt}, 32'(rxn));
		end_of_test();
	end
endmodule

// ### verilog/ast_baud_gen.sv
// Baud tick generator: one tick per bit time, derived from the divisor
`timescale 1ns/1ps
module ast_baud_gen (
	input  wire logic          sys_clk_in,
	input  wire logic          srst_in,
	input  wire logic          run_in,
	input  ast_pkg::ast_baud_t baud_in,
	output logic               bit_tick_out
);
	import ast_pkg::*;

	logic [15:0] div_cnt_reg;
	logic [6:0]  ovs_cnt_reg;
	logic [15:0] div_lim;
	logic [6:0]  ovs_lim;
	logic        ovs_tick;

	// Multiple of 64 only for narrow low-speed, else 16
	assign ovs_lim = (!baud_in.high_speed && !baud_in.wide) ?
		OVS_64 : OVS_16;
	// Narrow divisor uses only the low byte
	assign div_lim = baud_in.wide ? baud_in.divisor :
		{8'h00, baud_in.divisor[7:0]};
	assign ovs_tick = (div_cnt_reg == div_lim);

	// Divisor counter: period of divisor+1 system clocks
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !run_in || ovs_tick)
			div_cnt_reg <= 16'h0000;
		else
			div_cnt_reg <= div_cnt_reg + 16'h0001;
	end

	// Oversample counter: one bit tick per multiple of ticks
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !run_in) begin
			ovs_cnt_reg  <= 7'h00;
			bit_tick_out <= 1'b0;
		end else begin
			bit_tick_out <= 1'b0;
			if (ovs_tick) begin
				if (ovs_cnt_reg == ovs_lim - 7'h01) begin
					ovs_cnt_reg  <= 7'h00;
					bit_tick_out <= 1'b1;
				end else begin
					ovs_cnt_reg <= ovs_cnt_reg + 7'h01;
				end
			end
		end
	end
endmodule

// ### verilog/ast_pkg.sv
// Package: register map, field layout and constants of the serial transmitter
package ast_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_BAUD   = 8'h04;
	localparam logic [7:0] OFF_DATA   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_IMASK  = 8'h10;
	localparam logic [7:0] OFF_ISTAT  = 8'h14;
	// Control field positions
	localparam int CTRL_SERIAL_PORT_ENABLE   = 0;
	localparam int CTRL_SYNC   = 1;
	localparam int CTRL_TRANSMIT_ENABLE   = 2;
	localparam int CTRL_NINE   = 3;
	localparam int CTRL_NINTHD = 4;
	localparam int CTRL_HSPD   = 5;
	localparam int CTRL_WIDE   = 6;
	localparam int CTRL_TRANSMIT_INTERRUPT_ENABLE   = 7;
	localparam int CTRL_W      = 8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	// Status field positions
	localparam int STAT_TBE  = 0;
	localparam int STAT_SRE  = 1;
	// Interrupt status events
	localparam int EV_TBE  = 0;
	localparam int EV_DONE = 1;
	localparam int EV_W    = 2;
	// Oversampling multiples
	localparam logic [6:0] OVS_16 = 7'h10;
	localparam logic [6:0] OVS_64 = 7'h40;
	// Bus response
	localparam logic [31:0] RD_ZERO = 32'h00000000;

	// Frame settings record; the shifter reads ctrl_reg fields directly
	typedef struct packed {
		logic       nine;
		logic       ninth_bit;
		logic [7:0] data;
	} ast_frame_t;

	typedef struct packed {
		logic        high_speed;
		logic        wide;
		logic [15:0] divisor;
	} ast_baud_t;
endpackage

// ### verilog/ast_tx.sv
// Asynchronous serial transmitter with APB registers and interrupt
`timescale 1ns/1ps

// Operation
// - Asynchronous NRZ only when clocked mode clear
// - Start, eight or nine data, one stop
// - Data bits leave least significant first
// - One shared format and baud rate
// - Divisor makes 16x or 64x clock
// - No hardware parity; ninth bit from software
// - Available in all low-power modes
// - Shifter loads only after stop bit sent
// - Empty flag ignores enable; software cannot clear
// - Flag clears two cycles after buffer write
// - Shift-empty bit readable, polled, no interrupt
// - Transmit enable sets empty flag at once
// - Ninth bit from dedicated register bit
module ast_tx (
	input  wire logic        sys_clk_in,
	input  wire logic        srst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             tx_line_out,
	output logic             irq_out
);
	import ast_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_DATA  = 2'b10,
		ST_STOP  = 2'b11
	} ast_state_t;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [CTRL_W-1:0] ctrl_reg;
	logic [15:0]       baud_reg;
	logic [7:0]        hold_data_reg;
	logic              hold_full_reg;
	logic              flag_reg;
	logic              flag_delay_reg;
	logic [EV_W-1:0]   imask_reg;
	logic [EV_W-1:0]   istat_reg;
	logic              transmit_enable_q_reg;
	ast_state_t        state_reg;
	logic [8:0]        shift_reg;
	logic [3:0]        bit_cnt_reg;
	logic              nine_reg;
	logic              bit_tick;
	logic              run;
	logic              wr_en;
	logic              rd_en;
	logic              load;
	logic              frame_done;
	logic              shift_empty;
	logic              baud_run;
	ast_baud_t         baud;
	logic [EV_W-1:0]   ev;

	// Address decode shared by reads and writes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Offsets that answer without a bus error
	function automatic logic mapped(input logic [7:0] a);
		return hit(a, OFF_CTRL) || hit(a, OFF_BAUD)
			|| hit(a, OFF_DATA) || hit(a, OFF_STATUS)
			|| hit(a, OFF_IMASK) || hit(a, OFF_ISTAT);
	endfunction

	assign wr_en = psel_in && penable_in && pwrite_in && pready_out;
	assign rd_en = psel_in && !penable_in && !pwrite_in;

	// Port enabled, async mode, transmitter on; no power mode gating here
	assign run = ctrl_reg[CTRL_SERIAL_PORT_ENABLE] && !ctrl_reg[CTRL_SYNC]
		&& ctrl_reg[CTRL_TRANSMIT_ENABLE];

	assign baud.high_speed = ctrl_reg[CTRL_HSPD];
	assign baud.wide       = ctrl_reg[CTRL_WIDE];
	assign baud.divisor    = baud_reg;

	// Generator restarts at each load so the start bit is a full bit
	// time; a free-running phase could cut it short
	assign baud_run = run && state_reg != ST_IDLE;

	// One divisor and one frame format for the whole port
	ast_baud_gen u_baud (
		.sys_clk_in   (sys_clk_in),
		.srst_in      (srst_in),
		.run_in       (baud_run),
		.baud_in      (baud),
		.bit_tick_out (bit_tick)
	);

	// ****************************************************************
	// APB slave
	// ****************************************************************

	// Ready with no wait state: setup, then a single access cycle
	always_ff @(posedge sys_clk_in) begin
		if (srst_in)
			pready_out <= 1'b0;
		else
			pready_out <= psel_in && !penable_in;
	end

	// Read data captured in setup; unmapped offsets read zero
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			prdata_out <= RD_ZERO;
		end else if (rd_en) begin
			prdata_out <= RD_ZERO;
			if (hit(paddr_in, OFF_CTRL))
				prdata_out <= {24'h000000, ctrl_reg};
			else if (hit(paddr_in, OFF_BAUD))
				prdata_out <= {16'h0000, baud_reg};
			else if (hit(paddr_in, OFF_DATA))
				prdata_out <= {24'h000000, hold_data_reg};
			else if (hit(paddr_in, OFF_STATUS))
				prdata_out <= {30'h00000000, shift_empty,
					flag_reg};
			else if (hit(paddr_in, OFF_IMASK))
				prdata_out <= {30'h00000000, imask_reg};
			else if (hit(paddr_in, OFF_ISTAT))
				prdata_out <= {30'h00000000, istat_reg};
		end
	end

	// Error rises with pready for unmapped offsets, drops when idle
	always_ff @(posedge sys_clk_in) begin
		if (srst_in)
			pslverr_out <= 1'b0;
		else if (psel_in && !penable_in)
			pslverr_out <= !mapped(paddr_in);
		else if (!psel_in)
			pslverr_out <= 1'b0;
	end

	// Control, divisor and mask registers
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			ctrl_reg  <= CTRL_RESET;
			baud_reg  <= BAUD_RESET;
			imask_reg <= '0;
		end else if (wr_en) begin
			if (hit(paddr_in, OFF_CTRL))
				ctrl_reg <= pwdata_in[CTRL_W-1:0];
			else if (hit(paddr_in, OFF_BAUD))
				baud_reg <= pwdata_in[15:0];
			else if (hit(paddr_in, OFF_IMASK))
				imask_reg <= pwdata_in[EV_W-1:0];
		end
	end

	// ****************************************************************
	// Holding buffer and empty flag
	// ****************************************************************

	assign load = run && hold_full_reg && state_reg == ST_IDLE;

	// Shifter idle with nothing about to load; polled, no event
	assign shift_empty = state_reg == ST_IDLE && !load;

	// Buffer write fills; transfer to shifter empties in one cycle
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			hold_data_reg <= 8'h00;
			hold_full_reg <= 1'b0;
		end else if (wr_en && hit(paddr_in, OFF_DATA)) begin
			hold_data_reg <= pwdata_in[7:0];
			hold_full_reg <= 1'b1;
		end else if (load || !ctrl_reg[CTRL_TRANSMIT_ENABLE]) begin
			hold_full_reg <= 1'b0;
		end
	end

	// Flag follows buffer with one extra cycle; no software clear path
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			flag_delay_reg <= 1'b0;
			flag_reg       <= 1'b0;
			transmit_enable_q_reg     <= 1'b0;
		end else begin
			transmit_enable_q_reg     <= ctrl_reg[CTRL_TRANSMIT_ENABLE];
			flag_delay_reg <= wr_en && hit(paddr_in, OFF_DATA);
			if (ctrl_reg[CTRL_TRANSMIT_ENABLE] && !transmit_enable_q_reg)
				flag_reg <= 1'b1;
			else if (!ctrl_reg[CTRL_TRANSMIT_ENABLE])
				flag_reg <= 1'b0;
			else if (flag_delay_reg)
				flag_reg <= 1'b0;
			else if (!hold_full_reg)
				flag_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Frame shifter
	// ****************************************************************

	assign frame_done = bit_tick && state_reg == ST_STOP;

	// Start, data, stop sequence; parity never generated here
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !run) begin
			state_reg   <= ST_IDLE;
			shift_reg   <= 9'h000;
			bit_cnt_reg <= 4'h0;
			nine_reg    <= 1'b0;
			tx_line_out <= 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					tx_line_out <= 1'b1;
					if (load) begin
						shift_reg <= {ctrl_reg[CTRL_NINTHD],
							hold_data_reg};
						nine_reg    <= ctrl_reg[CTRL_NINE];
						bit_cnt_reg <= 4'h0;
						state_reg   <= ST_START;
						tx_line_out <= 1'b0;
					end
				end
				ST_START: begin
					if (bit_tick) begin
						tx_line_out <= shift_reg[0];
						shift_reg   <= {1'b0, shift_reg[8:1]};
						state_reg   <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (bit_tick) begin
						if (bit_cnt_reg == (nine_reg ? 4'h8 : 4'h7)) begin
							tx_line_out <= 1'b1;
							state_reg   <= ST_STOP;
						end else begin
							tx_line_out <= shift_reg[0];
							shift_reg   <= {1'b0, shift_reg[8:1]};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_STOP: begin
					if (bit_tick)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************

	assign ev[EV_TBE]  = flag_reg && ctrl_reg[CTRL_TRANSMIT_INTERRUPT_ENABLE];
	assign ev[EV_DONE] = frame_done;

	// Sticky status: set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk_in) begin
		if (srst_in)
			istat_reg <= '0;
		else if (wr_en && hit(paddr_in, OFF_ISTAT))
			istat_reg <= (istat_reg & ~pwdata_in[EV_W-1:0]) | ev;
		else
			istat_reg <= istat_reg | ev;
	end

	// Registered level interrupt from status or live events, and mask
	always_ff @(posedge sys_clk_in) begin
		if (srst_in)
			irq_out <= 1'b0;
		else
			irq_out <= |((istat_reg | ev) & imask_reg);
	end

	// ****************************************************************
	// Checks
	// ****************************************************************

	sequence s_hold_write;
		wr_en && hit(paddr_in, OFF_DATA) && ctrl_reg[CTRL_TRANSMIT_ENABLE];
	endsequence

	sequence s_last_data;
		run && state_reg == ST_DATA && bit_tick
			&& bit_cnt_reg == (nine_reg ? 4'h8 : 4'h7);
	endsequence

	a_idle_line_high: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) !run |=> tx_line_out)
		else $error("line not high while disabled");

	a_start_bit_low: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) load |=> !tx_line_out)
		else $error("no start bit after load");

	a_load_empties: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) load && !wr_en |=> !hold_full_reg)
		else $error("buffer not emptied by load");

	a_no_busy_load: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) load |-> state_reg == ST_IDLE)
		else $error("shifter loaded mid frame");

	a_flag_late_clear: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) s_hold_write ##1 ctrl_reg[CTRL_TRANSMIT_ENABLE]
		|=> !flag_reg)
		else $error("flag not clear two cycles after write");

	a_transmit_enable_sets_flag: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) $rose(ctrl_reg[CTRL_TRANSMIT_ENABLE]) |=> flag_reg)
		else $error("enable did not set flag");

	a_stop_high: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) state_reg == ST_STOP |-> tx_line_out)
		else $error("stop bit not high");

	a_async_only: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) ctrl_reg[CTRL_SYNC] |=> state_reg == ST_IDLE)
		else $error("frame sent in clocked mode");

	a_lsb_first: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) run && state_reg == ST_START && bit_tick
		|=> tx_line_out == $past(shift_reg[0]))
		else $error("first data bit not least significant");

	a_one_stop: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) s_last_data
		|=> state_reg == ST_STOP && tx_line_out)
		else $error("data bit count wrong");

	a_flag_sw_keep: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) flag_reg && ctrl_reg[CTRL_TRANSMIT_ENABLE]
		&& !flag_delay_reg |=> flag_reg)
		else $error("empty flag dropped without buffer write");

	a_empty_at_end: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) frame_done && !hold_full_reg && !wr_en
		|=> shift_empty)
		else $error("shifter not empty after stop bit");

	a_irq_masked: assert property (@(posedge sys_clk_in)
		disable iff (srst_in) imask_reg == '0 |=> !irq_out)
		else $error("interrupt while fully masked");
endmodule
